// File: inc/mac_port_pkg.sv
// Shared constants for the MAC client stream, pause and priority pause ports
// What this block does
// - Stream data 64 bits, 8 keep; narrow 32/4
// - Low transmit reset holds transmit path only
// - Low receive reset holds receive path only
// - User drives one keep bit per byte
// - Transmit user bit flags underrun; packet errored
// - Eight-bit input adjusts interframe gap
// - User marks final transmit beat with last
// - Device ready accepts transmit data
// - Receive user bit on last: good one
// - Receive beats carry valid; last on final
// - Pause request makes device send pause frame
// - Pause value captured when request asserts
// - Priority ports active only when option enabled
// - One receive hold request per priority 0..7
// - Quanta countdown waits for priority acknowledge
// - Unused priority acknowledge tied high
// - Priority request sends frame at next gap
package mac_port_pkg;
  localparam int DATA_W = 64;
  localparam int NARROW_DATA_W = 32;
  localparam int NUM_PRIO = 8;
  localparam int IFG_W = 8;
  localparam int PAUSE_W = 16;
  localparam int USER_W = 1;
  localparam int QUANTA_BITS = 512;
  localparam int PRESC_W = 8;
  localparam logic TX_READY_RST = 1'b1;
  localparam logic APP_READY_RST = 1'b0;
endpackage

// File: inc/mac_port_if.sv
// Interface joining the MAC device end and the user logic end
`timescale 1ns/1ps
interface mac_port_if #(
  parameter int DATA_W = mac_port_pkg::DATA_W
);
  import mac_port_pkg::*;
  logic tx_rst_n;
  logic [DATA_W-1:0] tx_data;
  logic [DATA_W/8-1:0] tx_keep;
  logic tx_valid;
  logic [USER_W-1:0] tx_user;
  logic [IFG_W-1:0] tx_ifg_delay;
  logic tx_last;
  logic tx_ready;
  logic rx_rst_n;
  logic [DATA_W-1:0] rx_data;
  logic [DATA_W/8-1:0] rx_keep;
  logic rx_valid;
  logic rx_user;
  logic rx_last;
  logic pause_req;
  logic [PAUSE_W-1:0] pause_val;
  logic [NUM_PRIO-1:0] rx_prio_hold_req;
  logic [NUM_PRIO-1:0] rx_prio_hold_ack;
  logic [NUM_PRIO-1:0] tx_prio_hold_req;

  // Device end: the MAC client ports
  modport dev (
    input tx_rst_n, tx_data, tx_keep, tx_valid, tx_user, tx_ifg_delay, tx_last,
    output tx_ready,
    input rx_rst_n,
    output rx_data, rx_keep, rx_valid, rx_user, rx_last,
    input pause_req, pause_val,
    output rx_prio_hold_req,
    input rx_prio_hold_ack, tx_prio_hold_req
  );

  // User end: packet logic and priority FIFOs
  modport usr (
    output tx_rst_n, tx_data, tx_keep, tx_valid, tx_user, tx_ifg_delay, tx_last,
    input tx_ready,
    output rx_rst_n,
    input rx_data, rx_keep, rx_valid, rx_user, rx_last,
    output pause_req, pause_val,
    input rx_prio_hold_req,
    output rx_prio_hold_ack, tx_prio_hold_req
  );
endinterface

// File: rtl/mac_dev_end.sv
// MAC device end: transmit skid buffer, receive stream, pause and priority pause logic
`timescale 1ns/1ps
module mac_dev_end #(
  parameter int DATA_W = mac_port_pkg::DATA_W, // 64, or 32 for the narrow path
  parameter bit PFC_EN = 1'b1 // Priority flow control build option
) (
  input wire logic clk_i, // 25 MHz clock
  input wire logic sys_rst_i, // Synchronous reset, high
  input wire logic ce_i, // Clock enable, freezes state when low
  mac_port_if.dev port, // Client-side ports
  output logic core_tx_valid_o, // Beat toward the transmit engine
  output logic [DATA_W-1:0] core_tx_data_o, // Beat data
  output logic [DATA_W/8-1:0] core_tx_keep_o, // Beat byte qualifiers
  output logic core_tx_last_o, // Final beat of packet
  output logic core_tx_err_o, // Packet errored, from the underrun beat to the final beat
  output logic [mac_port_pkg::IFG_W-1:0] core_tx_ifg_o, // Gap adjustment for this packet
  input wire logic core_tx_ready_i, // Transmit engine takes the beat
  output logic pause_send_o, // Send one pause frame
  output logic [mac_port_pkg::PAUSE_W-1:0] pause_time_o, // Pause time field
  input wire logic pause_done_i, // Pause frame taken
  output logic pfc_send_o, // Send one priority pause frame
  output logic [mac_port_pkg::NUM_PRIO-1:0] pfc_prio_o, // Priorities in that frame
  input wire logic pfc_done_i, // Priority frame taken
  input wire logic core_rx_valid_i, // Received beat valid
  input wire logic [DATA_W-1:0] core_rx_data_i, // Received data
  input wire logic [DATA_W/8-1:0] core_rx_keep_i, // Received byte qualifiers
  input wire logic core_rx_last_i, // Received final beat
  input wire logic core_rx_good_i, // Packet good, with final beat
  input wire logic [mac_port_pkg::NUM_PRIO-1:0] core_rx_pfc_load_i, // Priority pause frame seen
  input wire logic [mac_port_pkg::PAUSE_W-1:0] core_rx_pfc_quanta_i // Quanta for loaded priorities
);
  import mac_port_pkg::*;

  localparam int KEEP_W = DATA_W / 8;
  localparam int QUANTA_BEATS = QUANTA_BITS / DATA_W;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [KEEP_W-1:0] keep;
    logic last;
    logic err;
    logic [IFG_W-1:0] ifg;
  } beat_t;

  typedef struct packed {
    logic ready;
    beat_t out;
    logic out_v;
    beat_t skid;
    logic skid_v;
    logic err_acc;
    logic in_pkt;
    logic pause_prev;
    logic pause_pend;
    logic [PAUSE_W-1:0] pause_cap;
    logic pause_send;
    logic [PAUSE_W-1:0] pause_time;
    logic [NUM_PRIO-1:0] pfc_pend;
    logic pfc_send;
    logic [NUM_PRIO-1:0] pfc_prio;
  } tx_st_t;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
    logic [KEEP_W-1:0] keep;
    logic last;
    logic user;
    logic [PRESC_W-1:0] presc;
    logic [NUM_PRIO-1:0] hold;
    logic [NUM_PRIO-1:0][PAUSE_W-1:0] cnt;
  } rx_st_t;

  typedef struct packed {
    tx_st_t tx;
    rx_st_t rx;
  } st_t;

  st_t q;
  st_t d;
  beat_t in_beat;
  logic take;
  logic pop;
  logic idle;
  logic pause_issue;
  logic pfc_issue;
  logic tick;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    d = q;
    take = port.tx_valid & q.tx.ready;
    pop = q.tx.out_v & core_tx_ready_i;
    in_beat.data = port.tx_data;
    in_beat.keep = port.tx_keep;
    in_beat.last = port.tx_last;
    in_beat.err = port.tx_user[0] | q.tx.err_acc;
    in_beat.ifg = port.tx_ifg_delay;
    idle = ~q.tx.in_pkt;
    pause_issue = q.tx.pause_pend & ~q.tx.pause_send & idle;
    pfc_issue = PFC_EN & (|q.tx.pfc_pend) & ~q.tx.pfc_send & idle;
    tick = (q.rx.presc == PRESC_W'(QUANTA_BEATS - 1));

    // Underrun seen anywhere marks the rest of the packet bad
    if (take)
    begin
      d.tx.err_acc = port.tx_last ? 1'b0 : in_beat.err;
    end

    // Two-entry skid: output register plus one spare, so a stall loses nothing
    if (!q.tx.out_v || pop)
    begin
      if (q.tx.skid_v)
      begin
        d.tx.out = q.tx.skid;
        d.tx.skid_v = 1'b0;
      end
      else
      begin
        d.tx.out = take ? in_beat : q.tx.out;
        d.tx.out_v = take;
      end
    end
    else if (take)
    begin
      d.tx.skid = in_beat;
      d.tx.skid_v = 1'b1;
    end
    d.tx.ready = ~d.tx.skid_v;
    if (pop)
    begin
      d.tx.in_pkt = ~q.tx.out.last;
    end

    // Pause value is latched on the rising request, not at send time
    d.tx.pause_prev = port.pause_req;
    if (port.pause_req && !q.tx.pause_prev)
    begin
      d.tx.pause_cap = port.pause_val;
    end
    if (q.tx.pause_send && pause_done_i)
    begin
      d.tx.pause_send = 1'b0;
    end
    if (pause_issue)
    begin
      d.tx.pause_send = 1'b1;
      d.tx.pause_time = q.tx.pause_cap;
    end
    d.tx.pause_pend = (q.tx.pause_pend & ~pause_issue) | (port.pause_req & ~q.tx.pause_prev);

    // Priority requests gather until the link is between packets
    if (q.tx.pfc_send && pfc_done_i)
    begin
      d.tx.pfc_send = 1'b0;
    end
    if (pfc_issue)
    begin
      d.tx.pfc_send = 1'b1;
      d.tx.pfc_prio = q.tx.pfc_pend;
    end
    d.tx.pfc_pend = (pfc_issue ? '0 : q.tx.pfc_pend) | (PFC_EN ? port.tx_prio_hold_req : '0);

    // Receive stream has no back-pressure: registered straight through
    d.rx.valid = core_rx_valid_i;
    d.rx.data = core_rx_data_i;
    d.rx.keep = core_rx_keep_i;
    d.rx.last = core_rx_valid_i & core_rx_last_i;
    d.rx.user = core_rx_valid_i & core_rx_last_i & core_rx_good_i;

    // One tick per pause quantum of line time
    d.rx.presc = tick ? '0 : q.rx.presc + PRESC_W'(1);
    for (int p = 0; p < NUM_PRIO; p++)
    begin
      if (PFC_EN && core_rx_pfc_load_i[p])
      begin
        d.rx.cnt[p] = core_rx_pfc_quanta_i;
        d.rx.hold[p] = |core_rx_pfc_quanta_i;
      end
      else if (q.rx.hold[p] && port.rx_prio_hold_ack[p] && tick)
      begin
        d.rx.cnt[p] = q.rx.cnt[p] - PAUSE_W'(1);
        d.rx.hold[p] = (q.rx.cnt[p] != PAUSE_W'(1));
      end
    end

    // Path resets act on their own half only
    if (!port.tx_rst_n)
    begin
      d.tx = '0;
      d.tx.ready = TX_READY_RST;
    end
    if (!port.rx_rst_n)
    begin
      d.rx = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      q <= '0;
      q.tx.ready <= TX_READY_RST;
    end
    else if (ce_i)
    begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all taken from the state register
  assign port.tx_ready = q.tx.ready;
  assign port.rx_valid = q.rx.valid;
  assign port.rx_data = q.rx.data;
  assign port.rx_keep = q.rx.keep;
  assign port.rx_last = q.rx.last;
  assign port.rx_user = q.rx.user;
  assign port.rx_prio_hold_req = q.rx.hold;
  assign core_tx_valid_o = q.tx.out_v;
  assign core_tx_data_o = q.tx.out.data;
  assign core_tx_keep_o = q.tx.out.keep;
  assign core_tx_last_o = q.tx.out.last;
  assign core_tx_err_o = q.tx.out.err;
  assign core_tx_ifg_o = q.tx.out.ifg;
  assign pause_send_o = q.tx.pause_send;
  assign pause_time_o = q.tx.pause_time;
  assign pfc_send_o = q.tx.pfc_send;
  assign pfc_prio_o = q.tx.pfc_prio;
endmodule

// File: rtl/mac_user_end.sv
// User logic end: drives the MAC client ports from a registered application side
`timescale 1ns/1ps
module mac_user_end #(
  parameter int DATA_W = mac_port_pkg::DATA_W, // Stream width
  parameter logic [mac_port_pkg::NUM_PRIO-1:0] PRIO_USED = '1 // Priorities with a real FIFO
) (
  input wire logic clk_i, // 25 MHz clock
  input wire logic sys_rst_i, // Synchronous reset, high
  input wire logic ce_i, // Clock enable
  mac_port_if.usr port, // Toward the device
  input wire logic app_tx_rst_n_i, // Transmit path reset, low
  input wire logic app_rx_rst_n_i, // Receive path reset, low
  input wire logic app_tx_valid_i, // Application beat valid
  input wire logic [DATA_W-1:0] app_tx_data_i, // Beat data
  input wire logic [DATA_W/8-1:0] app_tx_keep_i, // Byte qualifiers
  input wire logic app_tx_last_i, // Final beat
  input wire logic app_tx_underrun_i, // Underrun flag
  input wire logic [mac_port_pkg::IFG_W-1:0] app_tx_ifg_i, // Gap adjustment
  output logic app_tx_ready_o, // Beat taken
  output logic app_rx_valid_o, // Received beat
  output logic [DATA_W-1:0] app_rx_data_o, // Received data
  output logic [DATA_W/8-1:0] app_rx_keep_o, // Received qualifiers
  output logic app_rx_last_o, // Received final beat
  output logic app_rx_good_o, // Good packet, with final beat
  input wire logic app_pause_req_i, // Pause request
  input wire logic [mac_port_pkg::PAUSE_W-1:0] app_pause_val_i, // Pause value
  input wire logic [mac_port_pkg::NUM_PRIO-1:0] app_tx_hold_req_i, // Priority pause requests
  input wire logic [mac_port_pkg::NUM_PRIO-1:0] app_rx_hold_ack_i, // FIFO acknowledges
  output logic [mac_port_pkg::NUM_PRIO-1:0] app_rx_hold_req_o // Hold requests to FIFOs
);
  import mac_port_pkg::*;

  typedef struct packed {
    logic tx_rst_n;
    logic rx_rst_n;
    logic ready;
    logic tx_v;
    logic [DATA_W-1:0] tx_data;
    logic [DATA_W/8-1:0] tx_keep;
    logic tx_last;
    logic tx_user;
    logic [IFG_W-1:0] ifg;
    logic pause_req;
    logic [PAUSE_W-1:0] pause_val;
    logic [NUM_PRIO-1:0] tx_hold;
    logic [NUM_PRIO-1:0] rx_ack;
    logic rx_v;
    logic [DATA_W-1:0] rx_data;
    logic [DATA_W/8-1:0] rx_keep;
    logic rx_last;
    logic rx_good;
    logic [NUM_PRIO-1:0] rx_hold;
  } st_t;

  st_t q;
  st_t d;
  logic take;

  ////////////////////////////////////////////////////////////////////////////
  // Next state; one holding register trades throughput for size
  always_comb
  begin
    d = q;
    take = app_tx_valid_i & q.ready;
    d.tx_rst_n = app_tx_rst_n_i;
    d.rx_rst_n = app_rx_rst_n_i;
    if (q.tx_v && port.tx_ready)
    begin
      d.tx_v = 1'b0;
    end
    if (take)
    begin
      d.tx_v = 1'b1;
      d.tx_data = app_tx_data_i;
      d.tx_keep = app_tx_keep_i;
      d.tx_last = app_tx_last_i;
      d.tx_user = app_tx_underrun_i;
      d.ifg = app_tx_ifg_i;
    end
    d.ready = ~d.tx_v;
    d.pause_req = app_pause_req_i;
    d.pause_val = app_pause_val_i;
    d.tx_hold = app_tx_hold_req_i;
    d.rx_ack = app_rx_hold_ack_i | ~PRIO_USED;
    // No stall toward the device: every beat is taken as it comes
    d.rx_v = port.rx_valid;
    d.rx_data = port.rx_data;
    d.rx_keep = port.rx_keep;
    d.rx_last = port.rx_last;
    d.rx_good = port.rx_user;
    d.rx_hold = port.rx_prio_hold_req;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      q <= '0;
      q.ready <= APP_READY_RST;
    end
    else if (ce_i)
    begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs from the state register
  assign port.tx_rst_n = q.tx_rst_n;
  assign port.rx_rst_n = q.rx_rst_n;
  assign port.tx_valid = q.tx_v;
  assign port.tx_data = q.tx_data;
  assign port.tx_keep = q.tx_keep;
  assign port.tx_last = q.tx_last;
  assign port.tx_user = USER_W'(q.tx_user);
  assign port.tx_ifg_delay = q.ifg;
  assign port.pause_req = q.pause_req;
  assign port.pause_val = q.pause_val;
  assign port.tx_prio_hold_req = q.tx_hold;
  assign port.rx_prio_hold_ack = q.rx_ack;
  assign app_tx_ready_o = q.ready;
  assign app_rx_valid_o = q.rx_v;
  assign app_rx_data_o = q.rx_data;
  assign app_rx_keep_o = q.rx_keep;
  assign app_rx_last_o = q.rx_last;
  assign app_rx_good_o = q.rx_good;
  assign app_rx_hold_req_o = q.rx_hold;
endmodule

// File: bench/mac_port_monitor.sv
// Checker on the client ports between the two ends
`timescale 1ns/1ps
module mac_port_monitor #(
  parameter int DATA_W = mac_port_pkg::DATA_W, // Stream width
  parameter logic [mac_port_pkg::NUM_PRIO-1:0] PRIO_USED = '1 // Priorities with a FIFO
) (
  input wire logic clk_i, // Clock
  input wire logic sys_rst_i, // Reset, high
  input wire logic tx_rst_n, // Tx path reset
  input wire logic [DATA_W-1:0] tx_data, // Tx beat
  input wire logic [DATA_W/8-1:0] tx_keep, // Tx qualifiers
  input wire logic tx_valid, // Tx offered
  input wire logic tx_last, // Tx final beat
  input wire logic tx_ready, // Tx taken
  input wire logic rx_rst_n, // Rx path reset
  input wire logic rx_valid, // Rx beat
  input wire logic rx_user, // Good packet
  input wire logic rx_last, // Rx final beat
  input wire logic [mac_port_pkg::NUM_PRIO-1:0] rx_prio_hold_req, // Hold requests
  input wire logic [mac_port_pkg::NUM_PRIO-1:0] rx_prio_hold_ack // Hold acknowledges
);
  import mac_port_pkg::*;
  default clocking mon_cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  ////////////////////////////////////////////////////////////////
  // Reset independence: each path only obeys its own reset
  ready_in_reset_a: assert property (!tx_rst_n |=> tx_ready)
    else $error("tx ready low in tx reset");
  rx_reset_quiet_a: assert property (!rx_rst_n |=> !rx_valid && rx_prio_hold_req == '0)
    else $error("rx active in rx reset");
  // Stream framing on both directions
  keep_nonzero_a: assert property (tx_valid |-> tx_keep != '0)
    else $error("tx beat without bytes");
  ready_drop_cause_a: assert property ($fell(tx_ready) |-> $past(tx_valid))
    else $error("tx ready fell without a beat");
  good_on_last_a: assert property (rx_user |-> rx_valid && rx_last)
    else $error("good flag off last beat");
  last_with_valid_a: assert property (rx_last |-> rx_valid)
    else $error("rx last without valid");
  tx_offer_held_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("tx beat withdrawn before taken");
  // A hold may only drop after a tick that saw its acknowledge high
  hold_needs_ack_a: assert property (rx_rst_n && $past(rx_rst_n) |-> ($past(rx_prio_hold_req) & ~rx_prio_hold_req
    & ~$past(rx_prio_hold_ack)) == '0)
    else $error("hold expired without acknowledge");
  unused_ack_high_a: assert property ($past(!sys_rst_i) |-> (rx_prio_hold_ack | PRIO_USED) == '1)
    else $error("unused acknowledge low");
  cover property (rx_user);
  cover property ($fell(tx_ready));
  cover property ($fell(rx_prio_hold_req[0]));
endmodule

// File: bench/testbench.sv
// Self-checking bench joining the device end and the user end
`timescale 1ns/1ps
module testbench;
  import mac_port_pkg::*;
  logic clk_i, sys_rst_i, ce_i, err_run, app_tx_rst_n_i, app_rx_rst_n_i, app_tx_valid_i, app_tx_last_i;
  logic app_tx_underrun_i, app_tx_ready_o, app_rx_valid_o, app_rx_last_o, app_rx_good_o, app_pause_req_i;
  logic [DATA_W-1:0] app_tx_data_i, app_rx_data_o, core_tx_data_o, core_rx_data_i;
  logic [DATA_W/8-1:0] app_tx_keep_i, app_rx_keep_o, core_tx_keep_o, core_rx_keep_i;
  logic [IFG_W-1:0] app_tx_ifg_i, core_tx_ifg_o;
  logic [PAUSE_W-1:0] app_pause_val_i, pause_time_o, core_rx_pfc_quanta_i;
  logic [NUM_PRIO-1:0] app_tx_hold_req_i, app_rx_hold_ack_i, app_rx_hold_req_o, pfc_prio_o, core_rx_pfc_load_i;
  logic core_tx_valid_o, core_tx_last_o, core_tx_err_o, core_tx_ready_i, pause_send_o, pause_done_i;
  logic pfc_send_o, pfc_done_i, core_rx_valid_i, core_rx_last_i, core_rx_good_i;
  logic [81:0] tx_exp[$], tx_got[$], rx_exp[$], rx_got[$];
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  mac_port_if #(.DATA_W(DATA_W)) mac_port_if_i ();
  mac_dev_end #(.DATA_W(DATA_W), .PFC_EN(1'b1)) mac_dev_end_i (.clk_i, .sys_rst_i, .ce_i, .port(mac_port_if_i),
    .core_tx_valid_o, .core_tx_data_o, .core_tx_keep_o, .core_tx_last_o, .core_tx_err_o, .core_tx_ifg_o,
    .core_tx_ready_i, .pause_send_o, .pause_time_o, .pause_done_i, .pfc_send_o, .pfc_prio_o, .pfc_done_i,
    .core_rx_valid_i, .core_rx_data_i, .core_rx_keep_i, .core_rx_last_i, .core_rx_good_i, .core_rx_pfc_load_i,
    .core_rx_pfc_quanta_i);
  // Priority 7 has no FIFO, so its acknowledge is forced high
  mac_user_end #(.DATA_W(DATA_W), .PRIO_USED(8'h7F)) mac_user_end_i (.clk_i, .sys_rst_i, .ce_i,
    .port(mac_port_if_i), .app_tx_rst_n_i, .app_rx_rst_n_i, .app_tx_valid_i, .app_tx_data_i, .app_tx_keep_i,
    .app_tx_last_i, .app_tx_underrun_i, .app_tx_ifg_i, .app_tx_ready_o, .app_rx_valid_o, .app_rx_data_o,
    .app_rx_keep_o, .app_rx_last_o, .app_rx_good_o, .app_pause_req_i, .app_pause_val_i, .app_tx_hold_req_i,
    .app_rx_hold_ack_i, .app_rx_hold_req_o);
  mac_port_monitor #(.DATA_W(DATA_W), .PRIO_USED(8'h7F)) mac_port_monitor_i (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .tx_rst_n(mac_port_if_i.tx_rst_n), .tx_data(mac_port_if_i.tx_data),
    .tx_keep(mac_port_if_i.tx_keep), .tx_valid(mac_port_if_i.tx_valid), .tx_last(mac_port_if_i.tx_last),
    .tx_ready(mac_port_if_i.tx_ready), .rx_rst_n(mac_port_if_i.rx_rst_n), .rx_valid(mac_port_if_i.rx_valid),
    .rx_user(mac_port_if_i.rx_user), .rx_last(mac_port_if_i.rx_last),
    .rx_prio_hold_req(mac_port_if_i.rx_prio_hold_req), .rx_prio_hold_ack(mac_port_if_i.rx_prio_hold_ack));
  ////////////////////////////////////////////////////////////////
  // Clock, 40 ns period
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // Collectors and hang guard; the far ends never stall the rx stream
  always @(posedge clk_i)
  begin
    if (core_tx_valid_o === 1'b1 && core_tx_ready_i === 1'b1)
      tx_got.push_back({core_tx_last_o, core_tx_err_o, core_tx_ifg_o, core_tx_keep_o, core_tx_data_o});
    if (app_rx_valid_o === 1'b1)
      rx_got.push_back({app_rx_last_o, app_rx_good_o, app_rx_keep_o, app_rx_data_o});
    cycles++;
    if (cycles == 2000)
    begin
      err_count++;
      $display("mismatch at %0t: timeout", $time);
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [81:0] got, input logic [81:0] exp, input string msg);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic drain(ref logic [81:0] got[$], ref logic [81:0] exp[$], input string what);
    check(got.size(), exp.size(), what);
    while (exp.size() > 0 && got.size() > 0)
      check(got.pop_front(), exp.pop_front(), what);
    got.delete();
    exp.delete();
    $display("test %s done", what);
  endtask
  // Error flag runs from the underrun beat to the end of its packet
  task automatic send_beat(input logic [63:0] d, input logic lst, input logic und, input logic [7:0] ifg);
    int n;
    logic [7:0] k;
    n = 0;
    k = lst ? 8'h0F : 8'hFF;
    err_run = err_run | und;
    tx_exp.push_back({lst, err_run, ifg, k, d});
    if (lst)
      err_run = 1'b0;
    @(posedge clk_i);
    app_tx_valid_i <= 1'b1;
    app_tx_data_i <= d;
    app_tx_keep_i <= k;
    app_tx_last_i <= lst;
    app_tx_underrun_i <= und;
    app_tx_ifg_i <= ifg;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (app_tx_ready_o !== 1'b1 && n < 100);
    app_tx_valid_i <= 1'b0;
  endtask
  task automatic rx_beat(input logic [63:0] d, input logic lst, input logic good);
    rx_exp.push_back({lst, lst & good, 8'hFF, d});
    @(posedge clk_i);
    core_rx_valid_i <= 1'b1;
    core_rx_data_i <= d;
    core_rx_keep_i <= 8'hFF;
    core_rx_last_i <= lst;
    core_rx_good_i <= good;
  endtask
  task automatic wait_send(input bit pfc);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while ((pfc ? pfc_send_o : pause_send_o) !== 1'b1 && n < 50);
    check(n < 50, 1'b1, "no frame request");
  endtask
  task give_verdict;
    $display("checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    err_run = 1'b0;
    {sys_rst_i, ce_i, app_tx_rst_n_i, app_rx_rst_n_i} <= 4'hF;
    {app_tx_valid_i, app_tx_last_i, app_tx_underrun_i, app_pause_req_i, core_tx_ready_i} <= '0;
    {app_tx_data_i, app_tx_keep_i, app_tx_ifg_i, app_pause_val_i, app_tx_hold_req_i, app_rx_hold_ack_i} <= '0;
    {pause_done_i, pfc_done_i, core_rx_valid_i, core_rx_data_i, core_rx_keep_i, core_rx_last_i} <= '0;
    {core_rx_good_i, core_rx_pfc_load_i, core_rx_pfc_quanta_i} <= '0;
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    // Drain side stalls until the buffer refuses, then empties it
    fork
      begin
        send_beat(64'hA1, 1'b0, 1'b0, 8'h0C);
        send_beat(64'hA2, 1'b1, 1'b0, 8'h0C);
        send_beat(64'hB1, 1'b0, 1'b1, 8'h20);
        send_beat(64'hB2, 1'b1, 1'b0, 8'hFF);
      end
      begin
        repeat (16) @(posedge clk_i);
        check(mac_port_if_i.tx_ready, 1'b0, "buffer not full");
        core_tx_ready_i <= 1'b1;
      end
    join
    repeat (8) @(posedge clk_i);
    drain(tx_got, tx_exp, "tx stream");
    rx_beat(64'hC1, 1'b0, 1'b1);
    rx_beat(64'hC2, 1'b1, 1'b1);
    rx_beat(64'hD1, 1'b1, 1'b0);
    @(posedge clk_i);
    core_rx_valid_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    drain(rx_got, rx_exp, "rx stream");
    // Value changes after the rise must not reach the frame
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk_i);
      app_pause_val_i <= i ? 16'hFFFF : 16'h1234;
      app_pause_req_i <= 1'b1;
      @(posedge clk_i);
      app_pause_val_i <= 16'h0BAD;
      wait_send(1'b0);
      check(pause_time_o, i ? 16'hFFFF : 16'h1234, "pause time");
      pause_done_i <= 1'b1;
      @(posedge clk_i);
      pause_done_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      check(pause_send_o, 1'b0, "pause repeated");
      app_pause_req_i <= 1'b0;
    end
    $display("test pause done");
    for (int p = 0; p < NUM_PRIO; p++)
    begin
      @(posedge clk_i);
      app_tx_hold_req_i <= 8'h01 << p;
      @(posedge clk_i);
      app_tx_hold_req_i <= 8'h00;
      wait_send(1'b1);
      check(pfc_prio_o, 8'h01 << p, "priority set");
      pfc_done_i <= 1'b1;
      @(posedge clk_i);
      pfc_done_i <= 1'b0;
    end
    $display("test priority pause done");
    // Quanta of 2 expire within 24 cycles once acknowledged
    core_rx_pfc_load_i <= 8'hFF;
    core_rx_pfc_quanta_i <= 16'h0002;
    @(posedge clk_i);
    core_rx_pfc_load_i <= 8'h00;
    repeat (4) @(posedge clk_i);
    check(app_rx_hold_req_o, 8'hFF, "hold requests");
    repeat (36) @(posedge clk_i);
    check(app_rx_hold_req_o, 8'h7F, "hold expiry");
    // Clock enable low must freeze the countdown even with acknowledges up
    app_rx_hold_ack_i <= 8'hFF;
    ce_i <= 1'b0;
    repeat (30) @(posedge clk_i);
    check(app_rx_hold_req_o, 8'h7F, "hold moved while frozen");
    ce_i <= 1'b1;
    repeat (40) @(posedge clk_i);
    check(app_rx_hold_req_o, 8'h00, "hold stuck");
    $display("test hold expiry done");
    app_rx_hold_ack_i <= 8'h00;
    core_rx_pfc_load_i <= 8'hFF;
    core_rx_pfc_quanta_i <= 16'h00FF;
    @(posedge clk_i);
    core_rx_pfc_load_i <= 8'h00;
    app_rx_rst_n_i <= 1'b0;
    send_beat(64'hE1, 1'b1, 1'b0, 8'h00);
    app_rx_rst_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    check(app_rx_hold_req_o, 8'h00, "rx reset");
    drain(tx_got, tx_exp, "tx in rx reset");
    app_tx_rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    app_tx_valid_i <= 1'b1;
    rx_beat(64'hF1, 1'b1, 1'b1);
    app_tx_valid_i <= 1'b0;
    @(posedge clk_i);
    core_rx_valid_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    app_tx_rst_n_i <= 1'b1;
    drain(tx_got, tx_exp, "tx reset");
    drain(rx_got, rx_exp, "rx in tx reset");
    give_verdict();
  end
endmodule
